// *** shared/serial_link_config_defines.svh ***
// Constants for the serial link configuration block
`ifndef SERIAL_LINK_CONFIG_DEFINES_SVH
`define SERIAL_LINK_CONFIG_DEFINES_SVH

// Selector values are the setting numbers used on the configuration port
`define SEL_NODE_ADDRESS   10'h0134
`define SEL_BIT_RATE       10'h0136
`define SEL_FRAME_FORMAT   10'h0137
`define SEL_PROTOCOL       10'h0138

`define RST_NODE_ADDRESS   16'h0001
`define RST_BIT_RATE       16'h0001
`define RST_FRAME_FORMAT   16'h0001
`define RST_PROTOCOL       16'h0001

`define MAX_NODE_ADDRESS   16'h00FF
`define MAX_BIT_RATE       16'h0002
`define MAX_FRAME_FORMAT   16'h0005
`define MAX_PROTOCOL       16'h000B
`define RSV_PROTOCOL_A     16'h0001
`define RSV_PROTOCOL_B     16'h0005

`define MODBUS_ADDR_MIN    8'h01
`define MODBUS_ADDR_MAX    8'hF7
`define BACNET_ADDR_MAX    8'hFE
`define N2_ADDR_MIN        8'h01

`endif

// *** shared/serial_link_config_pkg.sv ***
// Types shared by the serial link configuration block
package serial_link_config_pkg;

   typedef enum logic [2:0] {
      PROTO_OFF    = 3'b000,
      PROTO_KEYPAD = 3'b001,
      PROTO_MODBUS = 3'b010,
      PROTO_BACNET = 3'b011,
      PROTO_N2     = 3'b100
   } proto_t;

   typedef enum logic [1:0] {
      RATE_9600  = 2'b00,
      RATE_19200 = 2'b01,
      RATE_38400 = 2'b10
   } bit_rate_t;

   typedef struct packed {
      logic [9:0]  sel;
      logic [15:0] data;
   } cfg_write_t;

   typedef struct packed {
      proto_t     proto;
      bit_rate_t  bit_rate;
      logic       parity_en;
      logic       parity_odd;
      logic       two_stop;
   } port_cfg_t;

endpackage : serial_link_config_pkg

// *** testbench/cfg_source.sv ***
// Behavioural settings writer standing in for keypad or master
`timescale 1ns/1ns
module cfg_source (
   input  wire logic                         clk,
   output serial_link_config_pkg::cfg_write_t wr_req,
   output logic                              wr_en
);
   import serial_link_config_pkg::*;
   initial begin
      wr_en = 1'b0;
      wr_req = '0;
   end
   // Caller sits at a falling edge; addresses and link settings are its duty
   task send(logic [9:0] s, logic [15:0] d);
      wr_en = 1'b1;
      wr_req = '{s, d};
      @(negedge clk);
      wr_en = 1'b0;
      // Scrambled after release so nothing leans on a stale value
      wr_req.data = ~d;
   endtask : send
endmodule : cfg_source

// *** testbench/serial_link_config_monitor.sv ***
// Assertion checker for the serial link configuration block
`timescale 1ns/1ns
`include "serial_link_config_defines.svh"
module serial_link_config_monitor (
   input wire logic                               clk,
   input wire logic                               resetn,
   input wire logic                               motor_running,
   input wire logic                               wr_en,
   input wire serial_link_config_pkg::cfg_write_t wr_req,
   input wire logic                               wr_ack,
   input wire logic                               wr_refused,
   input wire logic [7:0]                         node_address,
   input wire logic                               address_valid,
   input wire serial_link_config_pkg::port_cfg_t  port1_cfg
);
   import serial_link_config_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_wr(logic [9:0] s); wr_en && !motor_running && wr_req.sel == s; endsequence
   property p_lock; wr_en && motor_running |=> wr_refused && !wr_ack; endproperty
   a_lock: assert property (p_lock) else $error("write taken in run");
   property p_answer; wr_en |=> wr_ack ^ wr_refused; endproperty
   a_answer: assert property (p_answer) else $error("bad write answer");
   property p_addr; s_wr(`SEL_NODE_ADDRESS) ##0 wr_req.data > 16'hff |=> wr_refused; endproperty
   a_addr: assert property (p_addr) else $error("address kept");
   property p_rate; s_wr(`SEL_BIT_RATE) ##0 wr_req.data > 16'h2 |=> wr_refused; endproperty
   a_rate: assert property (p_rate) else $error("rate kept");
   property p_frame; s_wr(`SEL_FRAME_FORMAT) ##0 wr_req.data > 16'h5 |=> wr_refused; endproperty
   a_frame: assert property (p_frame) else $error("frame kept");
   property p_proto; s_wr(`SEL_PROTOCOL) ##0 wr_req.data inside {16'h1, 16'h5}
      |=> wr_refused; endproperty
   a_proto: assert property (p_proto) else $error("reserved kept");
   property p_mbport; s_wr(`SEL_PROTOCOL) ##0 wr_req.data == 16'h2
      |=> ##1 port1_cfg.proto == PROTO_MODBUS; endproperty
   a_mbport: assert property (p_mbport) else $error("no modbus port");
   property p_mb; (port1_cfg.proto == PROTO_MODBUS && node_address > 8'hf7)[*2]
      |-> !address_valid; endproperty
   a_mb: assert property (p_mb) else $error("modbus address valid");
   property p_frc; port1_cfg.proto inside {PROTO_BACNET, PROTO_N2}
      |-> !port1_cfg.parity_en && !port1_cfg.two_stop; endproperty
   a_frc: assert property (p_frc) else $error("frame not forced");
endmodule : serial_link_config_monitor
bind serial_link_config serial_link_config_monitor u_mon (.clk, .resetn,
   .motor_running, .wr_en, .wr_req, .wr_ack, .wr_refused, .node_address,
   .address_valid, .port1_cfg);

// *** testbench/tb.sv ***
// Self-checking bench for the serial link configuration block
`timescale 1ns/1ns
`include "serial_link_config_defines.svh"
module tb;
   import serial_link_config_pkg::*;
   typedef struct {logic [9:0] s; logic [15:0] d; logic m, a;
      logic [15:0] r;} row_t;
   logic clk, resetn, motor_running, wr_en, wr_ack, wr_refused, address_valid;
   logic [9:0] rd_sel;
   logic [15:0] rd_data;
   logic [7:0] node_address;
   cfg_write_t wr_req;
   port_cfg_t port1_cfg, port2_cfg;
   int fails, num_checks, cyc;
   row_t rows [12] = '{'{10'h136,16'h2,0,1,16'h2}, '{10'h136,16'h3,0,0,16'h2},
      '{10'h137,16'h5,0,1,16'h5}, '{10'h137,16'h6,0,0,16'h5},
      '{10'h134,16'hff,0,1,16'hff}, '{10'h134,16'h100,0,0,16'hff},
      '{10'h138,16'h1,0,0,16'h1}, '{10'h138,16'h5,0,0,16'h1},
      '{10'h138,16'hc,0,0,16'h1}, '{10'h138,16'hb,0,1,16'hb},
      '{10'h134,16'h7,1,0,16'hff}, '{10'h100,16'h1,0,0,16'h0}};
   logic [9:0] ps [5] = '{10'h138, 10'h134, 10'h138, 10'h134, 10'h138};
   logic [15:0] pd [5] = '{16'h2, 16'hf7, 16'h3, 16'hff, 16'h0};
   logic [15:0] pe [5] = '{16'hae, 16'haf, 16'he1, 16'he0, 16'h40};
   serial_link_config u_dut (.clk, .resetn, .motor_running, .wr_en, .wr_req,
      .rd_sel, .rd_data, .wr_ack, .wr_refused, .node_address, .address_valid,
      .port1_cfg, .port2_cfg);
   cfg_source u_src (.clk, .wr_req, .wr_en);
   task chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task rd(logic [9:0] s, logic [15:0] e);
      rd_sel = s;
      @(negedge clk);
      chk("rd_data", e, rd_data);
   endtask : rd
   task wrap_up;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole run needs under a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         wrap_up;
      end
   end
   initial begin
      resetn = 1'b0;
      motor_running = 1'b0;
      rd_sel = 10'h0;
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[i]) begin
         motor_running = rows[i].m;
         u_src.send(rows[i].s, rows[i].d);
         chk("ack", {14'h0, rows[i].a, !rows[i].a}, {14'h0, wr_ack, wr_refused});
         rd(rows[i].s, rows[i].r);
      end
      chk("port2", 16'h121, {7'h0, port2_cfg, address_valid});
      $display("test table done");
      for (int i = 0; i < 5; i++) begin
         u_src.send(ps[i], pd[i]);
         @(negedge clk);
         chk("port1", pe[i], {7'h0, port1_cfg, address_valid});
      end
      $display("test protocols done");
      resetn = 1'b0;
      @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      chk("node", 16'h1, {8'h0, node_address});
      chk("port1", 16'h0, {8'h0, port1_cfg});
      rd(`SEL_NODE_ADDRESS, 16'h1);
      rd(`SEL_BIT_RATE, 16'h1);
      rd(`SEL_FRAME_FORMAT, 16'h1);
      rd(`SEL_PROTOCOL, 16'h1);
      $display("test reset done");
      wrap_up;
   end
endmodule : tb

// *** verilog/serial_link_config.sv ***
// Serial port configuration settings with run-time write protection
`timescale 1ns/1ns
`include "serial_link_config_defines.svh"

// Functional notes
// R01 - Node address holds 0 to 255, resets to 1, names this node.
// R02 - Under Modbus RTU only addresses 1 to 247 count as valid.
// R03 - BACnet valid range 0 to 254; N2 valid range 1 to 255.
// R04 - Network configurer gives each node a unique address.
// R05 - Bit rate code 0/1/2 means 9600/19200/38400, reset value 1.
// R06 - All nodes share one bit rate and one frame format.
// R07 - Frame always 8 data bits; codes 0-5 pick parity and stop bits.
// R08 - BACnet or N2 active forces frame code 0.
// R09 - A keypad port ignores bit rate and frame settings.
// R10 - Protocol codes 0 to 11 map port functions; 1 and 5 reserved.
// R11 - Settings change only with the motor stopped; else refused.
// R12 - Protocol code 2 makes port 1 a Modbus RTU slave.
// R13 - Reserved or out-of-range writes are refused, old value kept.
module serial_link_config (
   input  wire logic                              clk,
   input  wire logic                              resetn,
   input  wire logic                              motor_running,
   input  wire logic                              wr_en,
   input  wire serial_link_config_pkg::cfg_write_t wr_req,
   input  wire logic [9:0]                        rd_sel,
   output logic [15:0]                            rd_data,
   output logic                                   wr_ack,
   output logic                                   wr_refused,
   output logic [7:0]                             node_address,
   output logic                                   address_valid,
   output serial_link_config_pkg::port_cfg_t      port1_cfg,
   output serial_link_config_pkg::port_cfg_t      port2_cfg
);
   import serial_link_config_pkg::*;

   logic [1:0]  rst_sync;
   logic        rst_n;

   logic [15:0] serial_node_address;
   logic [15:0] serial_bit_rate_select;
   logic [15:0] serial_frame_format;
   logic [15:0] serial_protocol_select;

   // Port function for one protocol code; port2 selects the second port
   function automatic proto_t proto_of(input logic [15:0] code,
                                       input logic        port2);
      proto_t p;
      p = PROTO_OFF;
      unique case (code[3:0]) // R10
         4'h0: p = port2 ? PROTO_OFF : PROTO_KEYPAD;
         4'h2: p = port2 ? PROTO_OFF : PROTO_MODBUS; // R12
         4'h3: p = port2 ? PROTO_OFF : PROTO_BACNET;
         4'h4: p = port2 ? PROTO_OFF : PROTO_N2;
         4'h6: p = port2 ? PROTO_MODBUS : PROTO_KEYPAD;
         4'h7: p = port2 ? PROTO_MODBUS : PROTO_OFF;
         4'h8: p = port2 ? PROTO_BACNET : PROTO_KEYPAD;
         4'h9: p = port2 ? PROTO_BACNET : PROTO_OFF;
         4'hA: p = port2 ? PROTO_N2 : PROTO_KEYPAD;
         4'hB: p = port2 ? PROTO_N2 : PROTO_OFF;
         default: p = PROTO_OFF;
      endcase
      if (code > `MAX_PROTOCOL) begin
         p = PROTO_OFF;
      end
      return p;
   endfunction : proto_of

   // Line settings seen by one port
   function automatic port_cfg_t port_cfg_of(input proto_t     p,
                                             input logic [15:0] rate,
                                             input logic [15:0] frame);
      port_cfg_t c;
      logic [2:0] f;
      c.proto = p;
      // Keypad and idle ports carry no line settings
      if (p == PROTO_OFF || p == PROTO_KEYPAD) begin // R09
         c.bit_rate = RATE_9600;
         f = 3'd0;
      end else begin
         c.bit_rate = bit_rate_t'(rate[1:0]); // R05 R06
         f = frame[2:0];
      end
      if (p == PROTO_BACNET || p == PROTO_N2) begin
         f = 3'd0; // R08
      end
      // Codes 0-2 one stop bit, 3-5 two stop bits; 8 data bits always
      c.two_stop   = (f >= 3'd3); // R07
      c.parity_en  = (f == 3'd1) || (f == 3'd2) || (f == 3'd4)
                     || (f == 3'd5);
      c.parity_odd = (f == 3'd2) || (f == 3'd5);
      return c;
   endfunction : port_cfg_of

   // Reset release through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Write decode
   wire sel_addr  = (wr_req.sel == `SEL_NODE_ADDRESS);
   wire sel_rate  = (wr_req.sel == `SEL_BIT_RATE);
   wire sel_frame = (wr_req.sel == `SEL_FRAME_FORMAT);
   wire sel_proto = (wr_req.sel == `SEL_PROTOCOL);
   wire sel_any   = sel_addr | sel_rate | sel_frame | sel_proto;

   wire proto_code_ok = (wr_req.data <= `MAX_PROTOCOL)
                        && (wr_req.data != `RSV_PROTOCOL_A)
                        && (wr_req.data != `RSV_PROTOCOL_B);
   wire data_ok = (sel_addr  && wr_req.data <= `MAX_NODE_ADDRESS) // R01
                | (sel_rate  && wr_req.data <= `MAX_BIT_RATE)
                | (sel_frame && wr_req.data <= `MAX_FRAME_FORMAT)
                | (sel_proto && proto_code_ok); // R13

   // Running motor locks every setting
   wire wr_take  = wr_en && sel_any && data_ok && !motor_running; // R11
   wire wr_block = wr_en && !wr_take; // R11 R13

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_node_address    <= `RST_NODE_ADDRESS; // R01
         serial_bit_rate_select <= `RST_BIT_RATE; // R05
         serial_frame_format    <= `RST_FRAME_FORMAT; // R07
         serial_protocol_select <= `RST_PROTOCOL;
      end else if (wr_take) begin
         if (sel_addr) begin
            serial_node_address <= wr_req.data;
         end
         if (sel_rate) begin
            serial_bit_rate_select <= wr_req.data;
         end
         if (sel_frame) begin
            serial_frame_format <= wr_req.data;
         end
         if (sel_proto) begin
            serial_protocol_select <= wr_req.data;
         end
      end
   end

   // Effective configuration
   wire proto_t    p1 = proto_of(serial_protocol_select, 1'b0);
   wire proto_t    p2 = proto_of(serial_protocol_select, 1'b1);
   // Only one network runs at a time, so one range check suffices
   wire proto_t    net_p = (p2 != PROTO_OFF) ? p2 : p1;
   wire [7:0]      addr8 = serial_node_address[7:0];
   wire            next_address_valid =
      (net_p == PROTO_MODBUS) ? (addr8 >= `MODBUS_ADDR_MIN
                                 && addr8 <= `MODBUS_ADDR_MAX) : // R02
      (net_p == PROTO_BACNET) ? (addr8 <= `BACNET_ADDR_MAX) : // R03
      (net_p == PROTO_N2)     ? (addr8 >= `N2_ADDR_MIN) : // R03
      1'b0;
   wire port_cfg_t next_port1 = port_cfg_of(p1, serial_bit_rate_select,
                                            serial_frame_format);
   wire port_cfg_t next_port2 = port_cfg_of(p2, serial_bit_rate_select,
                                            serial_frame_format);
   wire [15:0]     next_rd_data =
      (rd_sel == `SEL_NODE_ADDRESS) ? serial_node_address :
      (rd_sel == `SEL_BIT_RATE)     ? serial_bit_rate_select :
      (rd_sel == `SEL_FRAME_FORMAT) ? serial_frame_format :
      (rd_sel == `SEL_PROTOCOL)     ? serial_protocol_select :
      16'h0000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data       <= 16'h0000;
         wr_ack        <= 1'b0;
         wr_refused    <= 1'b0;
         node_address  <= 8'h00;
         address_valid <= 1'b0;
         port1_cfg     <= '0;
         port2_cfg     <= '0;
      end else begin
         rd_data       <= next_rd_data;
         wr_ack        <= wr_take;
         wr_refused    <= wr_block;
         node_address  <= addr8; // R01
         address_valid <= next_address_valid;
         port1_cfg     <= next_port1;
         port2_cfg     <= next_port2;
      end
   end

endmodule : serial_link_config
